//--- rtl/sci_control_registers.sv
// serial unit with its control registers on a classic wishbone slave
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "sci_consts.svh"

module sci_control_registers #(
    parameter logic [7:0] BAUD_DIV_RST = `SCI_BAUD_RST
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic infrared_select_in,
    input wire logic rxd_in,
    output logic txd_out,
    output logic txd_oe_out,
    output logic port_ctl_out,
    output logic tx_irq_out,
    output logic rx_irq_out
);
    import sci_pkg::*;

    logic [7:0] frame_q;
    logic [7:0] irqc_q;
    logic [3:0] errie_q;
    logic [7:0] baud_q;
    logic tx_ninth_bit_q;
    logic rx_ninth_bit_q;
    logic [7:0] serial_data_buffer_q;
    logic [7:0] tx_buf_q;
    logic tx_empty_flag_q;
    logic tx_done_flag_q;
    logic rx_full_flag_q;
    logic idle_flag_q;
    logic overrun_q;
    logic frame_err_q;
    logic parity_err_q;

    // register view
    logic unit_on, loop_back_select, wake_addr, idle_count_start_select;
    logic transmitter_on, receiver_on, rx_standby, send_break_ctl;
    frame_cfg_s cfg;
    logic [3:0] frame_len;

    assign loop_back_select = frame_q[`SCI_FR_LOOP];
    assign unit_on = frame_q[`SCI_FR_ON];
    assign wake_addr = frame_q[`SCI_FR_WAKE];
    assign idle_count_start_select = frame_q[`SCI_FR_IDLE_COUNT_START_SELECT];
    assign cfg.nine = frame_q[`SCI_FR_NINE];
    assign cfg.par_on = frame_q[`SCI_FR_PAR_ON];
    assign cfg.par_odd = frame_q[`SCI_FR_PAR_ODD];
    assign transmitter_on = irqc_q[`SCI_IC_TX_ON];
    assign receiver_on = irqc_q[`SCI_IC_RX_ON];
    assign rx_standby = irqc_q[`SCI_IC_STANDBY];
    assign send_break_ctl = irqc_q[`SCI_IC_BREAK];
    assign frame_len = cfg.nine ? `SCI_LEN9 : `SCI_LEN8;

    // bus slave: ack one cycle after the request, effects at the ack edge
    logic [5:0] idx;
    logic bus_done, wr_lo, rd_data, wr_data;
    assign idx = wb_adr_in[7:2];
    assign bus_done = wb_cyc_in && wb_stb_in && wb_ack_out;
    assign wr_lo = bus_done && wb_we_in && wb_sel_in[0];
    assign rd_data = bus_done && !wb_we_in && idx == `SCI_IDX_DATA;
    assign wr_data = wr_lo && idx == `SCI_IDX_DATA;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
            wb_dat_out <= 32'h0000_0000;
            if (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in) begin
                unique case (idx)
                    `SCI_IDX_FRAME: wb_dat_out[7:0] <= frame_q;
                    `SCI_IDX_IRQ: wb_dat_out[7:0] <= irqc_q;
                    `SCI_IDX_NINTH: wb_dat_out[7:0] <= {rx_ninth_bit_q,
                        tx_ninth_bit_q, 2'b00, errie_q};
                    `SCI_IDX_STATUS: wb_dat_out[7:0] <= {tx_empty_flag_q,
                        tx_done_flag_q, rx_full_flag_q, idle_flag_q,
                        overrun_q, 1'b0, frame_err_q, parity_err_q};
                    `SCI_IDX_DATA: wb_dat_out[7:0] <= serial_data_buffer_q;
                    `SCI_IDX_BAUD: wb_dat_out[7:0] <= baud_q;
                    default: wb_dat_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            frame_q <= `SCI_FRAME_RST;
        end else if (wr_lo && idx == `SCI_IDX_FRAME) begin
            frame_q <= wb_dat_in[7:0];
        end
    end

    logic wake_evt;
    // control register two; hardware wakeup beats a software write
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irqc_q <= `SCI_IRQ_RST;
        end else begin
            if (wr_lo && idx == `SCI_IDX_IRQ) begin
                irqc_q <= wb_dat_in[7:0];
            end
            if (wake_evt) begin
                irqc_q[`SCI_IC_STANDBY] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            errie_q <= `SCI_ERRIE_RST;
            baud_q <= BAUD_DIV_RST;
        end else begin
            if (wr_lo && idx == `SCI_IDX_NINTH) begin
                errie_q <= wb_dat_in[3:0];
            end
            if (wr_lo && idx == `SCI_IDX_BAUD) begin
                baud_q <= wb_dat_in[7:0];
            end
        end
    end

    // transmit ninth bit keeps its value across reset
    always_ff @(posedge clk_in) begin
        if (wr_lo && idx == `SCI_IDX_NINTH) begin
            tx_ninth_bit_q <= wb_dat_in[`SCI_N9_TX];
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_data) begin
            tx_buf_q <= wb_dat_in[7:0];
        end
    end

    // baud generator: one oversample tick per divisor period
    logic [7:0] baud_cnt_q;
    logic os_tick;
    assign os_tick = unit_on && baud_cnt_q == baud_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !unit_on || os_tick) begin
            baud_cnt_q <= 8'h00;
        end else begin
            baud_cnt_q <= baud_cnt_q + 8'h01;
        end
    end

    logic [3:0] tx_sub_q;
    logic tx_bit_en;
    assign tx_bit_en = os_tick && tx_sub_q == `SCI_OVERSAMPLE;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !unit_on) begin
            tx_sub_q <= 4'h0;
        end else if (os_tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
        end
    end

    // transmitter
    logic [10:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic tx_busy_q, pre_pend_q, te_prev_q, brk_tail_q;
    logic tx_line, load_data;
    assign tx_line = tx_busy_q ? tx_sh_q[0] : 1'b1;

    // enable rising edge queues a preamble, also mid-character
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !unit_on) begin
            te_prev_q <= 1'b0;
        end else begin
            te_prev_q <= transmitter_on;
        end
    end

    logic next_frame;
    assign next_frame = tx_bit_en && (!tx_busy_q || tx_cnt_q == 4'h1);
    assign load_data = next_frame && transmitter_on && !pre_pend_q &&
        !send_break_ctl && !brk_tail_q && !tx_empty_flag_q && !wr_data;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !unit_on) begin
            pre_pend_q <= 1'b0;
        end else if (transmitter_on && !te_prev_q) begin
            pre_pend_q <= 1'b1;
        end else if (next_frame && transmitter_on) begin
            pre_pend_q <= 1'b0;
        end
    end

    logic [8:0] tx_char;
    logic tx_par;
    assign tx_char = {tx_ninth_bit_q, tx_buf_q};
    assign tx_par = parity_of(tx_char, cfg);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !unit_on) begin
            tx_busy_q <= 1'b0;
            tx_cnt_q <= 4'h0;
            tx_sh_q <= 11'h7FF;
            brk_tail_q <= 1'b0;
        end else if (tx_bit_en && tx_busy_q && tx_cnt_q != 4'h1) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
        end else if (next_frame) begin
            // a frame in flight always completes before this point
            tx_busy_q <= transmitter_on;
            tx_cnt_q <= frame_len;
            if (!transmitter_on) begin
                tx_busy_q <= 1'b0;
            end else if (pre_pend_q) begin
                // preamble of all ones, one frame long
                tx_sh_q <= 11'h7FF;
            end else if (send_break_ctl) begin
                // breaks back to back while held
                tx_sh_q <= 11'h000;
                brk_tail_q <= 1'b1;
            end else if (brk_tail_q) begin
                // single high bit after the last break
                tx_sh_q <= 11'h7FF;
                tx_cnt_q <= 4'h1;
                brk_tail_q <= 1'b0;
            end else if (load_data) begin
                // parity or ninth bit beside the data
                if (cfg.nine) begin
                    tx_sh_q <= {1'b1, cfg.par_on ? tx_par : tx_ninth_bit_q,
                        tx_buf_q, 1'b0};
                end else begin
                    tx_sh_q <= {2'b11, cfg.par_on ? tx_par : tx_buf_q[7],
                        tx_buf_q[6:0], 1'b0};
                end
            end else begin
                tx_busy_q <= 1'b0;
            end
        end
    end

    // transmit flags; a load setting empty wins over nothing here
    // because loads are held off in the cycle of a data write
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !unit_on) begin
            tx_empty_flag_q <= 1'b1;
            tx_done_flag_q <= 1'b1;
        end else begin
            if (load_data) begin
                tx_empty_flag_q <= 1'b1;
            end else if (wr_data) begin
                tx_empty_flag_q <= 1'b0;
            end
            tx_done_flag_q <= tx_empty_flag_q && !tx_busy_q && !pre_pend_q
                && !(transmitter_on && (send_break_ctl || brk_tail_q));
        end
    end

    // infrared: zero bits become a short low pulse, decoder stretches it
    logic [3:0] ir_hold_q;
    logic rx_pin_line, rx_line;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !unit_on) begin
            ir_hold_q <= 4'h0;
        end else if (!rxd_in) begin
            ir_hold_q <= `SCI_OVERSAMPLE;
        end else if (os_tick && ir_hold_q != 4'h0) begin
            ir_hold_q <= ir_hold_q - 4'h1;
        end
    end
    assign rx_pin_line = infrared_select_in ?
        (rxd_in && ir_hold_q == 4'h0) : rxd_in;
    // loop taken before the infrared encoder and after the decoder
    assign rx_line = loop_back_select ? tx_line : rx_pin_line;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            txd_out <= 1'b1;
            txd_oe_out <= 1'b0;
            port_ctl_out <= 1'b1;
        end else begin
            port_ctl_out <= !unit_on;
            txd_oe_out <= unit_on && (transmitter_on || tx_busy_q);
            if (infrared_select_in && !tx_line) begin
                txd_out <= tx_sub_q >= `SCI_IR_PULSE;
            end else begin
                txd_out <= tx_line;
            end
        end
    end

    // receiver
    rx_state_e rx_state_q;
    logic [3:0] rx_sub_q, rx_bitn_q, ones_q;
    logic [9:0] rx_sh_q, rx_sh_next;
    logic rx_run, mid, frame_end, idle_evt, idle_arm_q;
    logic [7:0] rx_data;
    logic rx_b8, rx_msb, rx_par_bad;
    assign rx_run = unit_on && receiver_on;
    assign mid = os_tick && rx_sub_q == `SCI_MID_SAMPLE;
    assign rx_sh_next = {rx_line, rx_sh_q[9:1]};
    assign frame_end = rx_state_q == RX_FRAME && mid &&
        rx_bitn_q == frame_len - 4'h1;
    assign rx_data = cfg.nine ? rx_sh_next[7:0] : rx_sh_next[8:1];
    assign rx_b8 = cfg.nine ? rx_sh_next[8] : rx_sh_next[8];
    // address mark sits in the top character bit
    assign rx_msb = cfg.nine ? rx_sh_next[8] : rx_data[7];
    assign rx_par_bad = cfg.par_on &&
        parity_of({rx_b8, rx_data}, cfg) != rx_msb;

    // disabling the receiver stops the sequencer and clears the idle count
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !rx_run) begin
            rx_state_q <= RX_WAIT;
            rx_sub_q <= 4'h0;
            rx_bitn_q <= 4'h0;
        end else if (os_tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            unique case (rx_state_q)
                RX_WAIT: begin
                    if (!rx_line) begin
                        rx_state_q <= RX_FRAME;
                        rx_sub_q <= 4'h0;
                        rx_bitn_q <= 4'h0;
                    end
                end
                RX_FRAME: begin
                    if (mid) begin
                        rx_bitn_q <= rx_bitn_q + 4'h1;
                        if ((rx_bitn_q == 4'h0 && rx_line) || frame_end) begin
                            rx_state_q <= RX_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (mid && rx_state_q == RX_FRAME && rx_bitn_q != 4'h0) begin
            rx_sh_q <= rx_sh_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !rx_run) begin
            ones_q <= 4'h0;
        end else if (mid) begin
            if (!rx_line) begin
                ones_q <= 4'h0;
            end else if (rx_state_q == RX_FRAME && idle_count_start_select
                && !frame_end) begin
                ones_q <= 4'h0;
            end else if (ones_q != frame_len) begin
                ones_q <= ones_q + 4'h1;
            end
        end
    end
    assign idle_evt = mid && rx_line && ones_q == frame_len - 4'h1;

    assign wake_evt = rx_standby && (wake_addr ?
        (frame_end && rx_msb) : idle_evt);

    logic accept;
    assign accept = frame_end && (!rx_standby || wake_evt);

    // received character and flags; a set beats a read's clear
    always_ff @(posedge clk_in) begin
        if (accept && !rx_full_flag_q) begin
            serial_data_buffer_q <= rx_data;
            rx_ninth_bit_q <= cfg.nine ? rx_sh_next[8] : rx_data[7];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_full_flag_q <= 1'b0;
            overrun_q <= 1'b0;
            frame_err_q <= 1'b0;
            parity_err_q <= 1'b0;
        end else if (accept) begin
            rx_full_flag_q <= 1'b1;
            overrun_q <= rx_full_flag_q || (overrun_q && !rd_data);
            frame_err_q <= !rx_line || (frame_err_q && !rd_data);
            parity_err_q <= rx_par_bad || (parity_err_q && !rd_data);
        end else if (rd_data) begin
            rx_full_flag_q <= 1'b0;
            overrun_q <= 1'b0;
            frame_err_q <= 1'b0;
            parity_err_q <= 1'b0;
        end
    end

    // idle flag needs a received character since the last one
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            idle_flag_q <= 1'b0;
            idle_arm_q <= 1'b0;
        end else begin
            if (idle_evt && idle_arm_q && !rx_standby) begin
                idle_flag_q <= 1'b1;
                idle_arm_q <= 1'b0;
            end else if (rd_data) begin
                idle_flag_q <= 1'b0;
            end
            if (accept) begin
                idle_arm_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_irq_out <= 1'b0;
            rx_irq_out <= 1'b0;
        end else begin
            tx_irq_out <= unit_on &&
                ((tx_empty_flag_q && irqc_q[`SCI_IC_TXE_IE]) ||
                 (tx_done_flag_q && irqc_q[`SCI_IC_TXD_IE]));
            rx_irq_out <= !rx_standby &&
                ((rx_full_flag_q && irqc_q[`SCI_IC_RXF_IE]) ||
                 (idle_flag_q && irqc_q[`SCI_IC_IDLE_IE]));
        end
    end
endmodule

//--- rtl/sci_consts.svh
// register map, field positions, reset values and timing counts
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

`define SCI_IDX_FRAME 6'h13
`define SCI_IDX_IRQ 6'h14
`define SCI_IDX_NINTH 6'h15
`define SCI_IDX_STATUS 6'h16
`define SCI_IDX_DATA 6'h18
`define SCI_IDX_BAUD 6'h19

`define SCI_FR_LOOP 7
`define SCI_FR_ON 6
`define SCI_FR_NINE 4
`define SCI_FR_WAKE 3
`define SCI_FR_IDLE_COUNT_START_SELECT 2
`define SCI_FR_PAR_ON 1
`define SCI_FR_PAR_ODD 0

`define SCI_IC_TXE_IE 7
`define SCI_IC_TXD_IE 6
`define SCI_IC_RXF_IE 5
`define SCI_IC_IDLE_IE 4
`define SCI_IC_TX_ON 3
`define SCI_IC_RX_ON 2
`define SCI_IC_STANDBY 1
`define SCI_IC_BREAK 0

`define SCI_N9_RX 7
`define SCI_N9_TX 6

`define SCI_FRAME_RST 8'h00
`define SCI_IRQ_RST 8'h00
`define SCI_ERRIE_RST 4'h0
`define SCI_BAUD_RST 8'h00

`define SCI_LEN8 4'hA
`define SCI_LEN9 4'hB
`define SCI_OVERSAMPLE 4'hF
`define SCI_MID_SAMPLE 4'h7
`define SCI_IR_PULSE 4'h3

`endif

//--- rtl/sci_pkg.sv
// shared types and the parity helper for the serial unit
package sci_pkg;
    typedef enum logic {RX_WAIT, RX_FRAME} rx_state_e;

    typedef struct packed {
        logic nine;
        logic par_on;
        logic par_odd;
    } frame_cfg_s;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
    } char_s;

    function automatic logic parity_of(logic [8:0] d, frame_cfg_s c);
        logic p;
        p = c.nine ? ^d[7:0] : ^d[6:0];
        return p ^ c.par_odd;
    endfunction
endpackage

//--- dv/sci_control_registers_checker.sv
// port assertions for the serial unit
`timescale 1ns/1ps
`include "sci_consts.svh"
module sci_regs_checker (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic infrared_select_in,
    input wire logic rxd_in,
    input wire logic txd_out,
    input wire logic txd_oe_out,
    input wire logic port_ctl_out,
    input wire logic tx_irq_out,
    input wire logic rx_irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic req;
    assign req = wb_cyc_in && wb_stb_in;
    chk_ack_pulse: assert property (
        wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
    chk_ack_answer: assert property (
        req && !wb_ack_out |=> wb_ack_out) else $error("request not acked");
    chk_ack_cause: assert property (
        wb_ack_out |-> $past(req)) else $error("ack without request");
    chk_data_idle: assert property (
        !wb_ack_out |-> wb_dat_out == 32'h0) else $error("data not idle");
    chk_upper_zero: assert property (
        wb_dat_out[31:8] == 24'h0) else $error("upper data bits set");
    chk_reset_pins: assert property (disable iff (1'b0)
        !rst_n_in |=> txd_out && !txd_oe_out && port_ctl_out &&
        !tx_irq_out && !rx_irq_out && !wb_ack_out)
        else $error("pins not at reset level");
    chk_pins_port: assert property (
        port_ctl_out |-> !txd_oe_out) else $error("pin driven while off");
    chk_tx_irq_off: assert property (
        port_ctl_out && $past(port_ctl_out) |-> !tx_irq_out)
        else $error("tx interrupt with unit off");
    chk_irq_gated: assert property (
        wb_ack_out && wb_we_in && wb_sel_in[0] &&
        wb_adr_in[7:2] == `SCI_IDX_IRQ && wb_dat_in[7:4] == 4'h0
        |-> ##2 !tx_irq_out && !rx_irq_out)
        else $error("interrupt with enables clear");
    cover property (tx_irq_out);
    cover property (rx_irq_out);
    cover property ($rose(txd_oe_out));
endmodule
bind sci_control_registers sci_regs_checker i_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .infrared_select_in(infrared_select_in),
    .rxd_in(rxd_in), .txd_out(txd_out), .txd_oe_out(txd_oe_out),
    .port_ctl_out(port_ctl_out), .tx_irq_out(tx_irq_out),
    .rx_irq_out(rx_irq_out));

//--- dv/sci_remote_node.sv
// remote serial node on the far side of the pins
`timescale 1ns/1ps
module sci_remote_node #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk_in,
    input wire logic line_in,
    output logic rxd_out
);
    initial rxd_out = 1'b1;
    // start, bits lsb first, stop last
    task automatic send_frame(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            rxd_out <= bits[i];
            repeat (BIT_CLKS - 1) @(posedge clk_in);
        end
    endtask
    // sample mid-bit; bounded hunt for the start edge
    task automatic recv_frame(input int n, output logic [15:0] bits,
                              output int waited);
        bits = 16'h0;
        waited = 0;
        while (line_in !== 1'b0 && waited < 4000) begin
            @(posedge clk_in);
            waited++;
        end
        repeat (BIT_CLKS / 2) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            bits[i] = line_in;
            repeat (BIT_CLKS) @(posedge clk_in);
        end
    endtask
endmodule

//--- dv/test_sci_control_registers.sv
// bench: register accesses and serial frames
`timescale 1ns/1ps
`include "sci_consts.svh"
module test_sci_control_registers;
    logic clk_in, rst_n_in = 0, wb_cyc_in = 0, wb_we_in = 0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
    logic wb_ack_out, txd_out, txd_oe_out, port_ctl_out, rxd;
    logic tx_irq_out, rx_irq_out, ir_sel = 1'b0;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    logic [7:0] cfg_tab [4] = '{8'h40, 8'h42, 8'h53, 8'h50};
    logic [7:0] dat_tab [4] = '{8'hA5, 8'h35, 8'h3C, 8'h3C};
    logic n9_tab [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    // transmit pin pulled up while released
    wire line = txd_oe_out ? txd_out : 1'b1;
    sci_control_registers i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_cyc_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(4'h1), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .infrared_select_in(ir_sel), .rxd_in(rxd),
        .txd_out(txd_out), .txd_oe_out(txd_oe_out),
        .port_ctl_out(port_ctl_out), .tx_irq_out(tx_irq_out),
        .rx_irq_out(rx_irq_out));
    sci_remote_node i_node (.clk_in(clk_in), .line_in(line), .rxd_out(rxd));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out;
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // hold the request until ack is seen at an edge
    task automatic wb_cycle(input logic w, input logic [5:0] idx,
                            input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= {idx, 2'b00};
        wb_dat_in <= {24'h0, d};
        // the ack ends this wait; without one, only the bench timeout ends it
        do begin
            @(posedge clk_in);
        end while (wb_ack_out !== 1'b1);
        q = wb_dat_out[7:0];
        wb_cyc_in <= 1'b0;
        wb_we_in <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb_cycle(1'b1, idx, d, q);
    endtask
    task automatic chk_reg(input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] q;
        wb_cycle(1'b0, idx, 8'h00, q);
        cmp({8'h0, q}, {8'h0, e});
    endtask
    initial begin
        logic [15:0] got, exp;
        logic [8:0] d9;
        logic [7:0] q;
        int w;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        chk_reg(`SCI_IDX_FRAME, 8'h00);
        chk_reg(`SCI_IDX_IRQ, 8'h00);
        chk_reg(`SCI_IDX_STATUS, 8'hC0);
        chk_reg(6'h30, 8'h00);
        wr(`SCI_IDX_IRQ, 8'hF3);
        chk_reg(`SCI_IDX_IRQ, 8'hF3);
        wr(`SCI_IDX_IRQ, 8'h00);
        repeat (3) @(posedge clk_in);
        cmp({14'h0, tx_irq_out, rx_irq_out}, 16'h0);
        wr(`SCI_IDX_BAUD, 8'h00);
        wr(`SCI_IDX_FRAME, 8'h40);
        repeat (2) @(posedge clk_in);
        cmp({15'h0, port_ctl_out}, 16'h0);
        wr(`SCI_IDX_IRQ, 8'h88);
        for (int k = 0; k < 4; k++) begin
            d9 = {n9_tab[k], dat_tab[k]};
            if (cfg_tab[k][1] && cfg_tab[k][4])
                d9[8] = ^d9[7:0] ^ cfg_tab[k][0];
            if (cfg_tab[k][1] && !cfg_tab[k][4])
                d9[7] = ^d9[6:0] ^ cfg_tab[k][0];
            exp = cfg_tab[k][4] ? {5'h0, 1'b1, d9, 1'b0}
                                : {6'h0, 1'b1, d9[7:0], 1'b0};
            wr(`SCI_IDX_NINTH, {1'b0, n9_tab[k], 6'h00});
            wr(`SCI_IDX_FRAME, cfg_tab[k]);
            wr(`SCI_IDX_DATA, dat_tab[k]);
            i_node.recv_frame(cfg_tab[k][4] ? 11 : 10, got, w);
            cmp(got, exp);
            if (k == 0) cmp({15'h0, w >= 140 && w <= 172}, 16'h1);
        end
        cmp({15'h0, txd_oe_out}, 16'h1);
        wr(`SCI_IDX_IRQ, 8'h2C);
        i_node.send_frame({5'h00, 1'b1, 1'b0, 8'h96, 1'b0}, 11);
        for (int t = 0; t < 400 && rx_irq_out !== 1'b1; t++) @(posedge clk_in);
        cmp({15'h0, rx_irq_out}, 16'h1);
        chk_reg(`SCI_IDX_STATUS, 8'hE0);
        chk_reg(`SCI_IDX_DATA, 8'h96);
        chk_reg(`SCI_IDX_NINTH, 8'h40);
        repeat (2) @(posedge clk_in);
        cmp({15'h0, rx_irq_out}, 16'h0);
        // standby: only a character with its top bit set is taken
        wr(`SCI_IDX_FRAME, 8'h48);
        wr(`SCI_IDX_IRQ, 8'h2E);
        i_node.send_frame({6'h01, 8'h35, 1'b0}, 10);
        chk_reg(`SCI_IDX_STATUS, 8'hC0);
        i_node.send_frame({6'h01, 8'hB5, 1'b0}, 10);
        repeat (2) @(posedge clk_in);
        cmp({15'h0, rx_irq_out}, 16'h1);
        chk_reg(`SCI_IDX_IRQ, 8'h2C);
        chk_reg(`SCI_IDX_DATA, 8'hB5);
        // a break on the pin must not reach the looped receiver
        ir_sel <= 1'b1;
        wr(`SCI_IDX_FRAME, 8'hC0);
        fork
            i_node.send_frame(16'h0000, 10);
        join_none
        wr(`SCI_IDX_DATA, 8'hDC);
        for (int t = 0; t < 400 && rx_irq_out !== 1'b1; t++) @(posedge clk_in);
        chk_reg(`SCI_IDX_DATA, 8'hDC);
        chk_reg(`SCI_IDX_NINTH, 8'hC0);
        ir_sel <= 1'b0;
        wr(`SCI_IDX_FRAME, 8'h40);
        fork
            i_node.recv_frame(10, got, w);
            begin
                wr(`SCI_IDX_IRQ, 8'h09);
                repeat (20) @(posedge clk_in);
                wr(`SCI_IDX_IRQ, 8'h08);
            end
        join
        cmp(got, 16'h0);
        cmp({15'h0, line}, 16'h1);
        wr(`SCI_IDX_FRAME, 8'h00);
        repeat (2) @(posedge clk_in);
        cmp({15'h0, port_ctl_out}, 16'h1);
        wb_cycle(1'b0, `SCI_IDX_STATUS, 8'h00, q);
        cmp({8'h0, q & 8'hC0}, 16'h00C0);
        wr(`SCI_IDX_FRAME, 8'hBF);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        chk_reg(`SCI_IDX_FRAME, 8'h00);
        chk_reg(`SCI_IDX_IRQ, 8'h00);
        close_out;
    end
endmodule
